// *** logic/svc_mode_pkg.sv ***
// Package of constants and types for the service mode selector
package svc_mode_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int COOL_HOLD_MS = 5000;
    localparam int LEARN_HOLD_MS = 11000;
    localparam int BEEPSET_HOLD_MS = 16000;
    localparam int HEAT_WINDOW_MS = 300000;
    localparam int BEEPSET_TIMEOUT_MS = 20000;
    localparam int BEEP_ON_MS = 100;
    localparam int BEEP_GAP_MS = 100;
    localparam int BEEP_LONG_MS = 1000;
    localparam int MS_W = 19;
    localparam logic [MS_W-1:0] MS_ZERO = 19'h0_0000;
    localparam logic [MS_W-1:0] MS_ONE = 19'h0_0001;
    // APB register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CONTROL = 8'h04;
    localparam logic [7:0] REG_CODE = 8'h08;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [1:0] CODE_DEFAULT = 2'h0;
    localparam logic BEEP_EN_DEFAULT = 1'b1;
    // Remote commands
    localparam logic [3:0] CMD_UNIT_DEFAULT_RESTORE = 4'h1;
    localparam logic [3:0] CMD_CHECK = 4'h2;
    typedef enum logic [2:0] {
        MODE_IDLE = 3'b000,
        MODE_AUTO = 3'b001,
        MODE_COOL = 3'b011,
        MODE_HEAT = 3'b010,
        MODE_LEARN = 3'b110,
        MODE_BEEPWAIT = 3'b111,
        MODE_BEEPSET = 3'b101
    } mode_type;
endpackage : svc_mode_pkg

// *** logic/beep_if.sv ***
// Interface between the selector and its beep sequencer
`timescale 1ns/100ps
interface beep_if;
    logic start;
    logic [2:0] count;
    logic long_beep;
    logic busy;
    modport ctrl (output start, output count, output long_beep, input busy);
    modport gen (input start, input count, input long_beep, output busy);
endinterface : beep_if

// *** logic/beep_sequencer.sv ***
// Beep pattern generator driven by a millisecond tick
`timescale 1ns/100ps
module beep_sequencer (
    // Clock, reset and millisecond tick
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_tick,
    // Request side
    beep_if.gen req,
    // Buzzer
    output logic o_buzzer
);
    logic [2:0] left_q, left_d;
    logic [svc_mode_pkg::MS_W-1:0] ms_q, ms_d;
    logic on_q, on_d;
    logic long_q, long_d;

    always_comb begin
        left_d = left_q;
        ms_d = ms_q;
        on_d = on_q;
        long_d = long_q;
        if (req.start) begin
            left_d = req.count;
            long_d = req.long_beep;
            on_d = 1'b1;
            ms_d = svc_mode_pkg::MS_ZERO;
        end else if (left_q != 3'h0 && i_tick) begin
            ms_d = ms_q + svc_mode_pkg::MS_ONE;
            if (on_q && ms_q == (long_q ? svc_mode_pkg::MS_W'(svc_mode_pkg::BEEP_LONG_MS - 1)
                                        : svc_mode_pkg::MS_W'(svc_mode_pkg::BEEP_ON_MS - 1))) begin
                on_d = 1'b0;
                ms_d = svc_mode_pkg::MS_ZERO;
                left_d = left_q - 3'h1;
            end else if (!on_q && ms_q == svc_mode_pkg::MS_W'(svc_mode_pkg::BEEP_GAP_MS - 1)) begin
                on_d = 1'b1;
                ms_d = svc_mode_pkg::MS_ZERO;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            left_q <= 3'h0;
            ms_q <= svc_mode_pkg::MS_ZERO;
            on_q <= 1'b0;
            long_q <= 1'b0;
        end else begin
            left_q <= left_d;
            ms_q <= ms_d;
            on_q <= on_d;
            long_q <= long_d;
        end
    end

    assign req.busy = (left_q != 3'h0);
    assign o_buzzer = on_q && (left_q != 3'h0);
endmodule : beep_sequencer

// *** logic/service_button_mode_selector.sv ***
// Service button mode selector with remote code filter and APB registers
`timescale 1ns/100ps
// Operation
// RQ1 - A button press starts automatic operation at once; in forced cooling the logic keeps the mode on a press.
// RQ2 - A hold past five seconds beeps once at the fifth second and starts forced cooling.
// RQ3 - A second five-second hold within five minutes of forced cooling beeps twice and heats.
// RQ4 - A hold past eleven seconds beeps three times and stores the next remote command's code.
// RQ5 - A hold past sixteen seconds beeps four times and waits for restore then check commands.
// RQ6 - In beep setting mode each press toggles the receive beep, short for off, long for on.
// RQ7 - Each press in beep setting mode restarts its twenty-second timeout.
// RQ8 - Only remote commands whose code matches the stored one of four are acted on.
// RQ9 - The remote carries its jumper-set transmission code in every command.
// RQ10 - The unit default restore command returns all stored settings to defaults; the logic restores only the beep enable and keeps the stored code.
// RQ11 - When the twenty-second timeout expires the mode is left with the last setting kept.
module service_button_mode_selector #(
    parameter int HEAT_WINDOW_MS = svc_mode_pkg::HEAT_WINDOW_MS,
    parameter int BEEPSET_TIMEOUT_MS = svc_mode_pkg::BEEPSET_TIMEOUT_MS,
    parameter int TICK_CYCLES = svc_mode_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // Service button, high while held
    input wire logic i_button,
    // Received remote command, one-cycle strobe
    input wire logic i_rc_valid,
    input wire logic [1:0] i_rc_code,
    input wire logic [3:0] i_rc_cmd,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Unit outputs
    output logic [2:0] o_mode,
    output logic o_buzzer,
    output logic o_rc_accept,
    output logic [3:0] o_rc_cmd,
    output logic o_code_write
);
    logic tick;
    beep_if bif ();
    beep_sequencer u_beep (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_tick(tick),
        .req(bif.gen),
        .o_buzzer(o_buzzer)
    );

    // Millisecond tick; holds are judged in whole ms
    logic [31:0] div_q, div_d;
    assign tick = (div_q == 32'(TICK_CYCLES - 1));
    always_comb begin
        div_d = tick ? svc_mode_pkg::WORD_ZERO : div_q + 32'h0000_0001;
    end

    svc_mode_pkg::mode_type mode_q, mode_d;
    logic [svc_mode_pkg::MS_W-1:0] hold_q, hold_d;
    logic [svc_mode_pkg::MS_W-1:0] mtime_q, mtime_d;
    logic btn_q;
    logic [1:0] code_q, code_d;
    logic beep_en_q, beep_en_d;
    logic restore_seen_q, restore_seen_d;
    logic acc_q, acc_d;
    logic [3:0] cmd_q, cmd_d;
    logic cw_q, cw_d;
    logic in_heat_win;
    logic press, rc_match;
    logic [2:0] bcount;
    logic bstart, blong;
    logic wr_en, restore_cmd;

    assign press = i_button && !btn_q;
    assign rc_match = i_rc_valid && (i_rc_code == code_q); // RQ8
    assign in_heat_win = (mode_q == svc_mode_pkg::MODE_COOL) &&
                         (mtime_q < svc_mode_pkg::MS_W'(HEAT_WINDOW_MS));
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign restore_cmd = rc_match && (i_rc_cmd == svc_mode_pkg::CMD_UNIT_DEFAULT_RESTORE);

    always_comb begin
        mode_d = mode_q;
        hold_d = hold_q;
        mtime_d = mtime_q;
        code_d = code_q;
        beep_en_d = beep_en_q;
        restore_seen_d = restore_seen_q;
        acc_d = 1'b0;
        cmd_d = cmd_q;
        cw_d = 1'b0;
        bstart = 1'b0;
        bcount = 3'h0;
        blong = 1'b0;
        if (tick && mtime_q != {svc_mode_pkg::MS_W{1'b1}}) begin
            mtime_d = mtime_q + svc_mode_pkg::MS_ONE;
        end
        if (tick && i_button && hold_q != {svc_mode_pkg::MS_W{1'b1}}) begin
            hold_d = hold_q + svc_mode_pkg::MS_ONE;
        end
        if (!i_button) begin
            hold_d = svc_mode_pkg::MS_ZERO;
        end
        if (press) begin
            hold_d = svc_mode_pkg::MS_ZERO;
            if (mode_q == svc_mode_pkg::MODE_BEEPSET) begin
                beep_en_d = !beep_en_q; // RQ6
                bstart = 1'b1;
                bcount = 3'h1;
                blong = !beep_en_q; // RQ6
                mtime_d = svc_mode_pkg::MS_ZERO; // RQ7
            end else if (mode_q != svc_mode_pkg::MODE_COOL) begin
                mode_d = svc_mode_pkg::MODE_AUTO; // RQ1
            end
        end else if (tick && i_button && mode_q != svc_mode_pkg::MODE_BEEPSET) begin
            unique case (hold_q)
                svc_mode_pkg::MS_W'(svc_mode_pkg::COOL_HOLD_MS - 1): begin
                    bstart = 1'b1;
                    mtime_d = svc_mode_pkg::MS_ZERO;
                    if (in_heat_win) begin
                        mode_d = svc_mode_pkg::MODE_HEAT; // RQ3
                        bcount = 3'h2; // RQ3
                    end else begin
                        mode_d = svc_mode_pkg::MODE_COOL; // RQ2
                        bcount = 3'h1; // RQ2
                    end
                end
                svc_mode_pkg::MS_W'(svc_mode_pkg::LEARN_HOLD_MS - 1): begin
                    mode_d = svc_mode_pkg::MODE_LEARN; // RQ4
                    bstart = 1'b1;
                    bcount = 3'h3;
                end
                svc_mode_pkg::MS_W'(svc_mode_pkg::BEEPSET_HOLD_MS - 1): begin
                    mode_d = svc_mode_pkg::MODE_BEEPWAIT; // RQ5
                    restore_seen_d = 1'b0;
                    bstart = 1'b1;
                    bcount = 3'h4;
                end
                default: begin
                end
            endcase
        end
        if (mode_q == svc_mode_pkg::MODE_BEEPSET && !press &&
            mtime_q >= svc_mode_pkg::MS_W'(BEEPSET_TIMEOUT_MS)) begin
            mode_d = svc_mode_pkg::MODE_IDLE; // RQ11
        end
        // Learning takes any code, so it bypasses the filter
        if (mode_q == svc_mode_pkg::MODE_LEARN && i_rc_valid && !i_button) begin
            code_d = i_rc_code; // RQ4
            cw_d = 1'b1;
            mode_d = svc_mode_pkg::MODE_IDLE;
        end else if (rc_match) begin
            acc_d = 1'b1; // RQ8
            cmd_d = i_rc_cmd;
            if (mode_q == svc_mode_pkg::MODE_BEEPWAIT) begin
                if (i_rc_cmd == svc_mode_pkg::CMD_UNIT_DEFAULT_RESTORE) begin
                    restore_seen_d = 1'b1;
                end else if (restore_seen_q && i_rc_cmd == svc_mode_pkg::CMD_CHECK) begin
                    mode_d = svc_mode_pkg::MODE_BEEPSET; // RQ5
                    mtime_d = svc_mode_pkg::MS_ZERO;
                end else begin
                    restore_seen_d = 1'b0;
                end
            end
            if (restore_cmd) begin
                beep_en_d = svc_mode_pkg::BEEP_EN_DEFAULT; // RQ10
            end
        end
        if (wr_en && i_paddr == svc_mode_pkg::REG_CONTROL) begin
            beep_en_d = i_pwdata[0];
        end
        if (wr_en && i_paddr == svc_mode_pkg::REG_CODE) begin
            code_d = i_pwdata[1:0];
            cw_d = 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            div_q <= svc_mode_pkg::WORD_ZERO;
            mode_q <= svc_mode_pkg::MODE_IDLE;
            hold_q <= svc_mode_pkg::MS_ZERO;
            mtime_q <= svc_mode_pkg::MS_ZERO;
            btn_q <= 1'b0;
            code_q <= svc_mode_pkg::CODE_DEFAULT;
            beep_en_q <= svc_mode_pkg::BEEP_EN_DEFAULT;
            restore_seen_q <= 1'b0;
            acc_q <= 1'b0;
            cmd_q <= 4'h0;
            cw_q <= 1'b0;
        end else begin
            div_q <= div_d;
            mode_q <= mode_d;
            hold_q <= hold_d;
            mtime_q <= mtime_d;
            btn_q <= i_button;
            code_q <= code_d;
            beep_en_q <= beep_en_d;
            restore_seen_q <= restore_seen_d;
            acc_q <= acc_d;
            cmd_q <= cmd_d;
            cw_q <= cw_d;
        end
    end

    assign bif.start = bstart;
    assign bif.count = bcount;
    assign bif.long_beep = blong;

    // APB read mux; zero wait states
    always_comb begin
        o_prdata = svc_mode_pkg::WORD_ZERO;
        o_pslverr = 1'b0;
        unique case (i_paddr)
            svc_mode_pkg::REG_STATUS: o_prdata = {28'h000_0000, bif.busy, mode_q};
            svc_mode_pkg::REG_CONTROL: o_prdata = {31'h0000_0000, beep_en_q};
            svc_mode_pkg::REG_CODE: o_prdata = {30'h0000_0000, code_q};
            default: o_pslverr = i_psel && i_penable;
        endcase
    end
    assign o_pready = 1'b1;
    assign o_mode = mode_q;
    assign o_rc_accept = acc_q;
    assign o_rc_cmd = cmd_q;
    assign o_code_write = cw_q;

    property p_heat_two_beeps;
        @(posedge i_clock) disable iff (!i_nrst)
        (mode_q == svc_mode_pkg::MODE_COOL && mode_d == svc_mode_pkg::MODE_HEAT)
            |-> bstart && bcount == 3'h2;
    endproperty
    a_heat_two_beeps: assert property (p_heat_two_beeps) else $error("heat without two beeps"); // RQ3
    property p_filter;
        @(posedge i_clock) disable iff (!i_nrst)
        (i_rc_valid && i_rc_code != code_q) |=> !o_rc_accept;
    endproperty
    a_filter: assert property (p_filter) else $error("foreign code accepted"); // RQ8
    property p_toggle;
        @(posedge i_clock) disable iff (!i_nrst)
        (mode_q == svc_mode_pkg::MODE_BEEPSET && press && !wr_en && !restore_cmd)
            |=> beep_en_q != $past(beep_en_q) && mtime_q == svc_mode_pkg::MS_ZERO;
    endproperty
    a_toggle: assert property (p_toggle) else $error("beep toggle missed"); // RQ6
    property p_auto_press;
        @(posedge i_clock) disable iff (!i_nrst)
        (press && !i_rc_valid && mode_q != svc_mode_pkg::MODE_COOL &&
            mode_q != svc_mode_pkg::MODE_BEEPSET)
            |=> o_mode == svc_mode_pkg::MODE_AUTO;
    endproperty
    a_auto_press: assert property (p_auto_press) else $error("press without auto"); // RQ1
    // A nonzero hold count means the button was already held, so no press here
    sequence s_cool_step;
        tick && i_button && !i_rc_valid && !in_heat_win &&
            mode_q != svc_mode_pkg::MODE_BEEPSET &&
            hold_q == svc_mode_pkg::MS_W'(svc_mode_pkg::COOL_HOLD_MS - 1);
    endsequence
    sequence s_one_beep;
        bstart && bcount == 3'h1;
    endsequence
    property p_cool_entry;
        @(posedge i_clock) disable iff (!i_nrst)
        s_cool_step |-> s_one_beep ##1 o_mode == svc_mode_pkg::MODE_COOL;
    endproperty
    a_cool_entry: assert property (p_cool_entry) else $error("cool entry wrong"); // RQ2
    sequence s_learn_step;
        tick && i_button && !i_rc_valid && mode_q != svc_mode_pkg::MODE_BEEPSET &&
            hold_q == svc_mode_pkg::MS_W'(svc_mode_pkg::LEARN_HOLD_MS - 1);
    endsequence
    property p_learn_entry;
        @(posedge i_clock) disable iff (!i_nrst)
        s_learn_step |-> bstart && bcount == 3'h3 ##1 o_mode == svc_mode_pkg::MODE_LEARN;
    endproperty
    a_learn_entry: assert property (p_learn_entry) else $error("learn entry wrong"); // RQ4
    sequence s_wait_step;
        tick && i_button && !i_rc_valid && mode_q != svc_mode_pkg::MODE_BEEPSET &&
            hold_q == svc_mode_pkg::MS_W'(svc_mode_pkg::BEEPSET_HOLD_MS - 1);
    endsequence
    property p_wait_entry;
        @(posedge i_clock) disable iff (!i_nrst)
        s_wait_step |-> bstart && bcount == 3'h4 ##1
            o_mode == svc_mode_pkg::MODE_BEEPWAIT && !restore_seen_q;
    endproperty
    a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong"); // RQ5
    sequence s_check_after_restore;
        mode_q == svc_mode_pkg::MODE_BEEPWAIT && restore_seen_q && rc_match &&
            i_rc_cmd == svc_mode_pkg::CMD_CHECK;
    endsequence
    sequence s_beepset_fresh;
        o_mode == svc_mode_pkg::MODE_BEEPSET && mtime_q == svc_mode_pkg::MS_ZERO;
    endsequence
    property p_unlock;
        @(posedge i_clock) disable iff (!i_nrst)
        s_check_after_restore |=> s_beepset_fresh;
    endproperty
    a_unlock: assert property (p_unlock) else $error("beep setting not entered"); // RQ5
    property p_learn_store;
        @(posedge i_clock) disable iff (!i_nrst)
        (mode_q == svc_mode_pkg::MODE_LEARN && i_rc_valid && !i_button && !wr_en)
            |=> o_code_write && o_mode == svc_mode_pkg::MODE_IDLE &&
                code_q == $past(i_rc_code);
    endproperty
    a_learn_store: assert property (p_learn_store) else $error("code not learned"); // RQ4
    property p_restore;
        @(posedge i_clock) disable iff (!i_nrst)
        (restore_cmd && mode_q != svc_mode_pkg::MODE_LEARN &&
            !(wr_en && i_paddr == svc_mode_pkg::REG_CONTROL))
            |=> beep_en_q == svc_mode_pkg::BEEP_EN_DEFAULT;
    endproperty
    a_restore: assert property (p_restore) else $error("defaults not restored"); // RQ10
    property p_beepset_timeout;
        @(posedge i_clock) disable iff (!i_nrst)
        (mode_q == svc_mode_pkg::MODE_BEEPSET && !press &&
            mtime_q >= svc_mode_pkg::MS_W'(BEEPSET_TIMEOUT_MS))
            |=> o_mode == svc_mode_pkg::MODE_IDLE;
    endproperty
    a_beepset_timeout: assert property (p_beepset_timeout) else $error("no timeout"); // RQ11
endmodule : service_button_mode_selector

// *** sim/rc_remote_model.sv ***
// Behavioural handheld remote control
`timescale 1ns/100ps
module rc_remote_model (
    // Clock
    input wire logic i_clock,
    // Jumper setting on the remote board
    input wire logic [1:0] i_jumper,
    // Decoded command toward the unit
    output logic o_valid,
    output logic [1:0] o_code,
    output logic [3:0] o_cmd
);
    // Idle lines, set by the bench's own process so each line has one driver
    task automatic park;
        o_valid = 1'b0;
        o_code = 2'h0;
        o_cmd = 4'h0;
    endtask : park
    // One command frame, valid for one cycle
    task automatic send(input logic [3:0] cmd);
        @(posedge i_clock);
        o_valid <= 1'b1;
        o_code <= i_jumper;
        o_cmd <= cmd;
        @(posedge i_clock);
        // Released lines must not keep the last value
        o_valid <= 1'b0;
        o_code <= ~i_jumper;
        o_cmd <= ~cmd;
    endtask : send
endmodule : rc_remote_model

// *** sim/tb_top.sv ***
// Self-checking bench for the service mode selector
`timescale 1ns/100ps
module tb_top;
    localparam int TC = 2;
    logic i_clock, i_nrst, i_button, i_psel, i_penable, i_pwrite, err;
    logic buz_q = 1'b0;
    logic o_pready, o_pslverr, o_buzzer, o_rc_accept, o_code_write, rc_valid;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic [2:0] o_mode;
    logic [3:0] o_rc_cmd, rc_cmd;
    logic [1:0] rc_code, jumper;
    int error_cnt = 0;
    int tests_run = 0;
    int rises = 0;

    // Short timeout so the setting window expires soon after the second toggle press
    service_button_mode_selector #(.BEEPSET_TIMEOUT_MS(400), .TICK_CYCLES(TC)) dut_u (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_button(i_button),
        .i_rc_valid(rc_valid), .i_rc_code(rc_code), .i_rc_cmd(rc_cmd),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_mode(o_mode), .o_buzzer(o_buzzer), .o_rc_accept(o_rc_accept),
        .o_rc_cmd(o_rc_cmd), .o_code_write(o_code_write));
    rc_remote_model rc_u (.i_clock(i_clock), .i_jumper(jumper), .o_valid(rc_valid),
        .o_code(rc_code), .o_cmd(rc_cmd));

    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        buz_q <= o_buzzer;
        if (o_buzzer === 1'b1 && buz_q === 1'b0) rises++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask : cyc
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge i_clock);
            if (o_pready === 1'b1) break;
        end
        if (i == 16) begin
            error_cnt++;
            end_of_test();
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
        chk({31'h0000_0000, err}, {31'h0000_0000, e});
    endtask : rdchk
    task automatic press;
        @(posedge i_clock);
        i_button <= 1'b1;
        @(posedge i_clock);
        i_button <= 1'b0;
    endtask : press
    task automatic rc(input logic [1:0] c, input logic [3:0] cmd, input logic acc);
        @(posedge i_clock);
        jumper <= c;
        rc_u.send(cmd);
        #1 chk(o_rc_accept, acc);
        if (acc) chk(o_rc_cmd, cmd);
    endtask : rc
    // Hold past a threshold, then count the confirmation beeps
    task automatic hold(input int ms, input int beeps, input logic [2:0] m);
        int base;
        @(posedge i_clock);
        i_button <= 1'b1;
        cyc(ms * TC - 20);
        // Snapshot instead of clearing, so only the monitor writes the count
        #1 base = rises;
        cyc(40);
        #1 chk(o_mode, m);
        chk(o_buzzer, 1);
        @(posedge i_clock);
        i_button <= 1'b0;
        cyc(1200);
        chk(rises - base, beeps);
    endtask : hold

    initial begin
        #(95_000 * 20);
        error_cnt++;
        end_of_test();
    end
    task automatic test_registers;
        rdchk(svc_mode_pkg::REG_STATUS, 32'h0000_0000, 1'b0);
        rdchk(svc_mode_pkg::REG_CONTROL, 32'h0000_0001, 1'b0);
        rdchk(svc_mode_pkg::REG_CODE, 32'h0000_0000, 1'b0);
        rdchk(8'h0C, 32'h0000_0000, 1'b1);
        apb(1'b1, svc_mode_pkg::REG_CODE, 32'h0000_0002);
        rdchk(svc_mode_pkg::REG_CODE, 32'h0000_0002, 1'b0);
        $display("registers done");
    endtask : test_registers
    task automatic test_auto_filter;
        press();
        cyc(3);
        #1 chk(o_mode, svc_mode_pkg::MODE_AUTO);
        for (int c = 0; c < 4; c++) rc(c[1:0], 4'h5, c == 2);
        $display("auto and filter done");
    endtask : test_auto_filter
    task automatic test_forced_learn;
        hold(svc_mode_pkg::COOL_HOLD_MS, 1, svc_mode_pkg::MODE_COOL);
        hold(svc_mode_pkg::COOL_HOLD_MS, 2, svc_mode_pkg::MODE_HEAT);
        hold(svc_mode_pkg::LEARN_HOLD_MS, 3, svc_mode_pkg::MODE_LEARN);
        @(posedge i_clock);
        jumper <= 2'h0;
        rc_u.send(4'h5);
        #1 chk(o_code_write, 1);
        cyc(2);
        #1 chk(o_mode, svc_mode_pkg::MODE_IDLE);
        rdchk(svc_mode_pkg::REG_CODE, 32'h0000_0000, 1'b0);
        $display("forced and learn done");
    endtask : test_forced_learn
    task automatic test_beep_setting;
        apb(1'b1, svc_mode_pkg::REG_CONTROL, 32'h0000_0000);
        hold(svc_mode_pkg::BEEPSET_HOLD_MS, 4, svc_mode_pkg::MODE_BEEPWAIT);
        rc(2'h0, svc_mode_pkg::CMD_UNIT_DEFAULT_RESTORE, 1'b1);
        rdchk(svc_mode_pkg::REG_CONTROL, 32'h0000_0001, 1'b0);
        rc(2'h0, svc_mode_pkg::CMD_CHECK, 1'b1);
        cyc(1);
        #1 chk(o_mode, svc_mode_pkg::MODE_BEEPSET);
        press();
        cyc(4);
        #1 chk(o_buzzer, 1);
        rdchk(svc_mode_pkg::REG_CONTROL, 32'h0000_0000, 1'b0);
        cyc(300);
        #1 chk(o_buzzer, 0);
        cyc(300);
        press();
        cyc(300);
        #1 chk(o_buzzer, 1);
        cyc(200);
        #1 chk(o_mode, svc_mode_pkg::MODE_BEEPSET);
        cyc(320);
        #1 chk(o_mode, svc_mode_pkg::MODE_IDLE);
        rdchk(svc_mode_pkg::REG_CONTROL, 32'h0000_0001, 1'b0);
        $display("beep setting done");
    endtask : test_beep_setting

    initial begin
        i_nrst = 1'b0;
        i_button = 1'b0;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 8'h00;
        i_pwdata = 32'h0000_0000;
        jumper = 2'h0;
        rc_u.park();
        cyc(5);
        i_nrst <= 1'b1;
        test_registers();
        test_auto_filter();
        test_forced_learn();
        test_beep_setting();
        end_of_test();
    end
endmodule : tb_top
